//--- rtl/fbx_pkg.sv
// fbx_pkg: opcode codes, field positions and reset values for the nibble alu
package fbx_pkg;
    localparam int          WORD_W        = 10;
    localparam int          NIB_W         = 4;
    // full 10-bit opcodes
    localparam logic [9:0]  OP_ADD_MEM    = 10'h00a;
    localparam logic [9:0]  OP_ADD_MEM_C  = 10'h00b;
    localparam logic [9:0]  OP_SET_CARRY  = 10'h007;
    localparam logic [9:0]  OP_CLR_CARRY  = 10'h006;
    localparam logic [9:0]  OP_SKIP_CZ    = 10'h02f;
    localparam logic [9:0]  OP_AND        = 10'h018;
    localparam logic [9:0]  OP_OR         = 10'h019;
    localparam logic [9:0]  OP_CMPL       = 10'h01c;
    localparam logic [9:0]  OP_ROR        = 10'h01d;
    localparam logic [9:0]  OP_SKIP_EQ_M  = 10'h026;
    localparam logic [9:0]  OP_SKIP_EQ_I  = 10'h025;
    // base codes with low immediate field
    localparam logic [5:0]  OP_ADD_IMM_HI = 6'h06;  // 0 6 n
    localparam logic [5:0]  OP_LOAD_A_HI  = 6'h07;  // 0 7 n
    localparam logic [7:0]  OP_SET_BIT_HI = 8'h17;  // 0 5 c + j
    localparam logic [7:0]  OP_CLR_BIT_HI = 8'h13;  // 0 4 c + j
    localparam logic [7:0]  OP_TST_BIT_HI = 8'h08;  // 0 2 j
    localparam int          IMM4_LSB      = 0;
    localparam int          IMM2_LSB      = 0;
    // reset values
    localparam logic [3:0]  ACC_RST       = 4'h0;
    localparam logic        CARRY_RST     = 1'b0;
endpackage : fbx_pkg

//--- rtl/fbx_decode.sv
// fbx_decode: combinational opcode classifier for the nibble alu
`timescale 1ns/1ps
`default_nettype none
module fbx_decode (
    // instruction word
    input  wire logic [9:0] word,
    // one-hot class flags
    output logic            is_am,
    output logic            is_amc,
    output logic            is_addi,
    output logic            is_and,
    output logic            is_or,
    output logic            is_sc,
    output logic            is_rc,
    output logic            is_szc,
    output logic            is_cma,
    output logic            is_rar,
    output logic            is_sb,
    output logic            is_rb,
    output logic            is_szb,
    output logic            is_skip_if_equal_memory,
    output logic            is_sea,
    output logic            is_la
);
    // plain equality decode, no priority needed: codes never overlap
    assign is_am   = word == fbx_pkg::OP_ADD_MEM;
    assign is_amc  = word == fbx_pkg::OP_ADD_MEM_C;
    assign is_addi = word[9:4] == fbx_pkg::OP_ADD_IMM_HI;
    assign is_and  = word == fbx_pkg::OP_AND;
    assign is_or   = word == fbx_pkg::OP_OR;
    assign is_sc   = word == fbx_pkg::OP_SET_CARRY;
    assign is_rc   = word == fbx_pkg::OP_CLR_CARRY;
    assign is_szc  = word == fbx_pkg::OP_SKIP_CZ;
    assign is_cma  = word == fbx_pkg::OP_CMPL;
    assign is_rar  = word == fbx_pkg::OP_ROR;
    assign is_sb   = word[9:2] == fbx_pkg::OP_SET_BIT_HI;
    assign is_rb   = word[9:2] == fbx_pkg::OP_CLR_BIT_HI;
    assign is_szb  = word[9:2] == fbx_pkg::OP_TST_BIT_HI;
    assign is_skip_if_equal_memory = word == fbx_pkg::OP_SKIP_EQ_M;
    assign is_sea  = word == fbx_pkg::OP_SKIP_EQ_I;
    assign is_la   = word[9:4] == fbx_pkg::OP_LOAD_A_HI;
endmodule // fbx_decode
`default_nettype wire

//--- rtl/fbx_alu.sv
// fbx_alu: execution of arithmetic, bit and compare-skip instructions
`timescale 1ns/1ps
`default_nettype none
module fbx_alu (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // instruction stream
    input  wire logic       instr_valid,
    input  wire logic [9:0] instr,
    // memory nibble at the data pointer
    input  wire logic [3:0] mem_rdata,
    // architectural state
    output logic [3:0]      acc,
    output logic            carry_flag,
    // memory write back
    output logic            mem_we,
    output logic [3:0]      mem_wdata,
    // skip request for the next fetched word
    output logic            skip_next,
    // second word of compare-immediate pending
    output logic            sea_wait
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBX_ST_FIRST  = 2'b01,
        FBX_ST_SECOND = 2'b10
    } fbx_state_t;

    // compare-immediate is the only two-word instruction in this group
    fbx_state_t  state;
    fbx_state_t  next_state;
    logic        skip_now;   // current word is being skipped
    logic        last_la;    // previous valid word was load-immediate, neither skipped nor a compare operand
    // next values, all settled by the single combinational process
    logic [3:0]  next_acc;
    logic        next_carry;
    logic        next_mem_we;
    logic [3:0]  next_mem_wdata;
    logic        next_skip;
    logic        next_last_la;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        is_am;      // add memory
    logic        is_amc;     // add memory with carry
    logic        is_addi;    // add immediate
    logic        is_and;     // and memory
    logic        is_or;      // or memory
    logic        is_sc;      // set carry
    logic        is_rc;      // clear carry
    logic        is_szc;     // skip if carry zero
    logic        is_cma;     // complement accumulator
    logic        is_rar;     // rotate right through carry
    logic        is_sb;      // set memory bit
    logic        is_rb;      // clear memory bit
    logic        is_szb;     // skip if memory bit zero
    logic        is_skip_if_equal_memory;    // skip if equal memory
    logic        is_sea;     // skip if equal immediate, first word
    logic        is_la;      // load accumulator immediate

    // classifier kept apart so the execute logic reads as a table
    fbx_decode u_dec (
        .word    (instr),
        .is_am   (is_am),
        .is_amc  (is_amc),
        .is_addi (is_addi),
        .is_and  (is_and),
        .is_or   (is_or),
        .is_sc   (is_sc),
        .is_rc   (is_rc),
        .is_szc  (is_szc),
        .is_cma  (is_cma),
        .is_rar  (is_rar),
        .is_sb   (is_sb),
        .is_rb   (is_rb),
        .is_szb  (is_szb),
        .is_skip_if_equal_memory (is_skip_if_equal_memory),
        .is_sea  (is_sea),
        .is_la   (is_la)
    );

    // ------------------------------------------------------------
    // datapath terms
    // ------------------------------------------------------------
    // operand slices; the sums keep a fifth bit for the carry-out
    wire [3:0] imm4  = instr[fbx_pkg::IMM4_LSB +: 4];
    wire [1:0] bsel  = instr[fbx_pkg::IMM2_LSB +: 2];
    wire [3:0] bmask = 4'h1 << bsel;
    wire [4:0] sum_m  = {1'b0, acc} + {1'b0, mem_rdata};
    wire [4:0] sum_mc = sum_m + {4'h0, carry_flag};
    wire [4:0] sum_i  = {1'b0, acc} + {1'b0, imm4};
    wire       bit_zero = (mem_rdata & bmask) == 4'h0;
    // a load-immediate right after one is treated as skipped
    wire       la_chain = is_la && last_la;
    // the second compare word is an operand, never an instruction
    wire       in_second = state == FBX_ST_SECOND;
    wire       execute  = instr_valid && !skip_now && !la_chain;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_acc       = acc;
        next_carry     = carry_flag;
        next_mem_we    = 1'b0;
        next_mem_wdata = mem_rdata;
        next_skip      = skip_now;
        next_last_la   = last_la;
        // idle cycles keep state, acc, carry and skip; mem_we drops and mem_wdata follows mem_rdata
        if (instr_valid) begin
            next_skip    = 1'b0;
            next_last_la = is_la && !in_second && !skip_now;
            unique case (state)
                FBX_ST_SECOND: begin
                    // second word carries the immediate
                    next_state = FBX_ST_FIRST;
                    next_skip  = acc == imm4;
                end
                FBX_ST_FIRST: begin
                    // codes never overlap, so the ifs act as a parallel
                    // select; an unknown code matches none and does nothing
                    if (execute) begin
                        if (is_am)
                            next_acc = sum_m[3:0];
                        if (is_amc) begin
                            next_acc   = sum_mc[3:0];
                            next_carry = sum_mc[4];
                        end
                        if (is_addi) begin
                            next_acc  = sum_i[3:0];
                            next_skip = !sum_i[4];
                        end
                        if (is_and)
                            next_acc = acc & mem_rdata;
                        if (is_or)
                            next_acc = acc | mem_rdata;
                        if (is_sc)
                            next_carry = 1'b1;
                        if (is_rc)
                            next_carry = 1'b0;
                        if (is_szc)
                            next_skip = !carry_flag;
                        if (is_cma)
                            next_acc = ~acc;
                        if (is_rar) begin
                            next_acc   = {carry_flag, acc[3:1]};
                            next_carry = acc[0];
                        end
                        if (is_sb) begin
                            next_mem_we    = 1'b1;
                            next_mem_wdata = mem_rdata | bmask;
                        end
                        if (is_rb) begin
                            next_mem_we    = 1'b1;
                            next_mem_wdata = mem_rdata & ~bmask;
                        end
                        if (is_szb)
                            next_skip = bit_zero;
                        if (is_skip_if_equal_memory)
                            next_skip = acc == mem_rdata;
                        if (is_sea)
                            next_state = FBX_ST_SECOND;
                        if (is_la)
                            next_acc = imm4;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // one bank of flops; synchronous reset clears every output together
    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= FBX_ST_FIRST;
            acc        <= fbx_pkg::ACC_RST;
            carry_flag <= fbx_pkg::CARRY_RST;
            mem_we     <= 1'b0;
            mem_wdata  <= 4'h0;
            skip_now   <= 1'b0;
            last_la    <= 1'b0;
        end else begin
            state      <= next_state;
            acc        <= next_acc;
            carry_flag <= next_carry;
            mem_we     <= next_mem_we;
            mem_wdata  <= next_mem_wdata;
            skip_now   <= next_skip;
            last_la    <= next_last_la;
        end
    end

    // skip and wait flags come straight from flip-flops
    assign skip_next = skip_now;
    // one-hot code: bit 1 is the wait state itself, no gate on the pin
    assign sea_wait  = state[1];
endmodule // fbx_alu
`default_nettype wire

//--- verification/fbx_alu_checker.sv
// fbx_alu_checker: concurrent checks on the nibble alu ports
`timescale 1ns/1ps
`default_nettype none
module fbx_alu_checker (
    // clock, reset and stimulus
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       instr_valid,
    input  wire logic [9:0] instr,
    input  wire logic [3:0] mem_rdata,
    // state and results under watch
    input  wire logic [3:0] acc,
    input  wire logic       carry_flag,
    input  wire logic       mem_we,
    input  wire logic [3:0] mem_wdata,
    input  wire logic       skip_next,
    input  wire logic       sea_wait
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a word only acts when neither skipped nor a compare operand
    wire logic       ex;
    wire logic [3:0] bit_sel;
    assign ex      = instr_valid && !skip_next && !sea_wait;
    assign bit_sel = 4'h1 << instr[1:0];
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    am_sum_a: assert property (ex && instr == fbx_pkg::OP_ADD_MEM |=>
        acc == $past(acc) + $past(mem_rdata) && $stable(carry_flag))
        else $error("add memory result wrong");
    amc_sum_a: assert property (ex && instr == fbx_pkg::OP_ADD_MEM_C |=>
        {carry_flag, acc} == $past(acc) + $past(mem_rdata) + $past(carry_flag))
        else $error("add with carry result wrong");
    cmpl_acc_a: assert property (ex && instr == fbx_pkg::OP_CMPL |=>
        acc == ~$past(acc)) else $error("complement wrong");
    ror_carry_a: assert property (ex && instr == fbx_pkg::OP_ROR |=>
        {acc, carry_flag} == {$past(carry_flag), $past(acc)})
        else $error("rotate through carry wrong");
    set_bit_a: assert property (ex && instr[9:2] == fbx_pkg::OP_SET_BIT_HI
        |=> mem_we && mem_wdata == ($past(mem_rdata) | $past(bit_sel)))
        else $error("set bit write wrong");
    skip_quiet_a: assert property (instr_valid && skip_next |=>
        $stable(acc) && $stable(carry_flag) && !mem_we && !skip_next)
        else $error("skipped word changed state");
    skip_if_equal_memory_skip_a: assert property (ex && instr == fbx_pkg::OP_SKIP_EQ_M |=>
        skip_next == ($past(acc) == $past(mem_rdata)) && $stable(acc))
        else $error("memory compare skip wrong");
    sea_enter_a: assert property (
        ex && instr == fbx_pkg::OP_SKIP_EQ_I |=> sea_wait && !skip_next)
        else $error("compare wait not entered");
    sea_leave_a: assert property (sea_wait && instr_valid |=>
        !sea_wait && skip_next == ($past(acc) == $past(instr[3:0]))
        && $stable(acc)) else $error("compare immediate skip wrong");
    szc_skip_a: assert property (ex && instr == fbx_pkg::OP_SKIP_CZ |=>
        skip_next == !$past(carry_flag) && $stable(carry_flag))
        else $error("carry zero skip wrong");
    // main scenarios reached
    cover property (instr_valid && skip_next);
    cover property (sea_wait && instr_valid);
    cover property (mem_we);
endmodule // fbx_alu_checker

bind fbx_alu fbx_alu_checker i_fbx_alu_checker (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .mem_rdata(mem_rdata),
    .acc(acc), .carry_flag(carry_flag), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .skip_next(skip_next), .sea_wait(sea_wait));
`default_nettype wire

//--- verification/fbx_alu_test.sv
// fbx_alu_test: directed scenarios for the nibble alu
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %0t got %h want %h", $time, g, e); end end
module fbx_alu_test;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       instr_valid = 1'b0;
    logic [9:0] instr = 10'h000;
    logic [3:0] mem_rdata = 4'h0;
    logic [3:0] acc, mem_wdata;
    logic       carry_flag, mem_we, skip_next, sea_wait;
    int         err_total = 0, n_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    fbx_alu i_fbx_alu (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .mem_rdata(mem_rdata), .acc(acc),
        .carry_flag(carry_flag), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .skip_next(skip_next), .sea_wait(sea_wait));
    // ------------------------------------------------------------
    // drivers and scenarios
    // ------------------------------------------------------------
    // one word per cycle; results are settled by the next falling edge
    task automatic step(input logic [9:0] w, input logic [3:0] m);
        instr_valid = 1'b1;
        instr = w;
        mem_rdata = m;
        @(negedge clk);
    endtask
    // a filler word first swallows any skip left by the previous scenario
    task automatic setup(input logic [3:0] a, input logic c);
        step(10'h000, 4'h0);
        step(c ? fbx_pkg::OP_SET_CARRY : fbx_pkg::OP_CLR_CARRY, 4'h0);
        step({fbx_pkg::OP_LOAD_A_HI, a}, 4'h0);
    endtask
    task automatic t_arith;
        setup(4'h9, 1'b0);
        step(fbx_pkg::OP_ADD_MEM, 4'h8);
        `CHK({carry_flag, acc}, 5'h01)
        setup(4'h9, 1'b1);
        step(fbx_pkg::OP_ADD_MEM_C, 4'h5);
        `CHK({carry_flag, acc}, 5'h0f)
        step({fbx_pkg::OP_ADD_IMM_HI, 4'h0}, 4'h0);
        `CHK({skip_next, carry_flag, acc}, 6'h2f)
        step(10'h000, 4'h0);
        step({fbx_pkg::OP_ADD_IMM_HI, 4'h2}, 4'h0);
        `CHK({skip_next, carry_flag, acc}, 6'h01)
        step(fbx_pkg::OP_ADD_MEM_C, 4'hf);
        `CHK({carry_flag, acc}, 5'h10)
    endtask
    task automatic t_logic;
        setup(4'hc, 1'b0);
        step(fbx_pkg::OP_AND, 4'ha);
        `CHK(acc, 4'h8)
        step(fbx_pkg::OP_OR, 4'h3);
        `CHK(acc, 4'hb)
        step(fbx_pkg::OP_CMPL, 4'h0);
        `CHK({carry_flag, acc}, 5'h04)
    endtask
    task automatic t_carry;
        setup(4'h5, 1'b0);
        step(fbx_pkg::OP_SET_CARRY, 4'h0);
        `CHK({carry_flag, acc}, 5'h15)
        step(fbx_pkg::OP_SKIP_CZ, 4'h0);
        `CHK(skip_next, 1'b0)
        step(fbx_pkg::OP_CLR_CARRY, 4'h0);
        `CHK({carry_flag, acc}, 5'h05)
        step(fbx_pkg::OP_SKIP_CZ, 4'h0);
        `CHK(skip_next, 1'b1)
        step(fbx_pkg::OP_ROR, 4'h0);
        `CHK({skip_next, carry_flag, acc}, 6'h05)
        step(fbx_pkg::OP_ROR, 4'h0);
        `CHK({carry_flag, acc}, 5'h12)
        step(fbx_pkg::OP_ROR, 4'h0);
        `CHK({carry_flag, acc}, 5'h09)
    endtask
    task automatic t_bits;
        for (int j = 0; j < 4; j++) begin
            step(10'h05c + 10'(j), 4'h0);
            `CHK({mem_we, mem_wdata}, 5'h10 | 5'(1 << j))
            step(10'h04c + 10'(j), 4'hf);
            `CHK({mem_we, mem_wdata}, 5'h1f & ~5'(1 << j))
            step(10'h020 + 10'(j), 4'(1 << j));
            `CHK(skip_next, 1'b0)
            step(10'h020 + 10'(j), ~4'(1 << j));
            `CHK(skip_next, 1'b1)
            step(10'h05c + 10'(j), 4'h0);
            `CHK({skip_next, mem_we}, 2'b00)
        end
    endtask
    task automatic t_cmp;
        setup(4'h7, 1'b0);
        step(fbx_pkg::OP_SKIP_EQ_M, 4'h7);
        `CHK(skip_next, 1'b1)
        step(fbx_pkg::OP_SKIP_EQ_I, 4'h0);
        `CHK({sea_wait, skip_next}, 2'b00)
        step(fbx_pkg::OP_SKIP_EQ_M, 4'h6);
        `CHK({skip_next, acc}, 5'h07)
        step(fbx_pkg::OP_SKIP_EQ_I, 4'h0);
        `CHK(sea_wait, 1'b1)
        step(10'h077, 4'h0);
        `CHK({sea_wait, skip_next, acc}, 6'h17)
        step(10'h000, 4'h0);
        step(fbx_pkg::OP_SKIP_EQ_I, 4'h0);
        step(10'h075, 4'h0);
        `CHK({sea_wait, skip_next, acc}, 6'h07)
    endtask
    task automatic t_chain;
        step(fbx_pkg::OP_CLR_CARRY, 4'h0);
        step(10'h073, 4'h0);
        step(10'h079, 4'h0);
        `CHK(acc, 4'h3)
        step(fbx_pkg::OP_CLR_CARRY, 4'h0);
        step(10'h079, 4'h0);
        `CHK(acc, 4'h9)
    endtask
    // reset in mid-run, with carry set and a compare operand pending
    task automatic t_reset;
        step(fbx_pkg::OP_SET_CARRY, 4'h0);
        step(fbx_pkg::OP_SKIP_EQ_I, 4'h0);
        rst = 1'b1;
        instr_valid = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK({acc, carry_flag, mem_we, skip_next, sea_wait}, 8'h00)
        step({fbx_pkg::OP_ADD_IMM_HI, 4'h3}, 4'h0);
        `CHK({sea_wait, skip_next, carry_flag, acc}, 7'h23)
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard: the full run needs only about ninety cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        `CHK({acc, carry_flag, mem_we, skip_next, sea_wait}, 8'h00)
        t_arith();
        t_logic();
        t_carry();
        t_bits();
        t_cmp();
        t_chain();
        t_reset();
        finish_test();
    end
endmodule // fbx_alu_test
`default_nettype wire
